/* hdl/dpsc_defs.svh */
// Constants for the device power-state controller: register offsets, fields, state codes, resume length.
// Assumes inclusion by bare name from the package and design files.
`ifndef DPSC_DEFS_SVH
`define DPSC_DEFS_SVH
`define DPSC_OFF_PMCSR 12'h000
`define DPSC_OFF_BUSCTL 12'h004
`define DPSC_OFF_BUSST 12'h008
`define DPSC_OFF_IRQ_STAT 12'h00c
`define DPSC_OFF_IRQ_EN 12'h010
`define DPSC_OFF_IRQ_CLR 12'h014
`define DPSC_OFF_USBCTL 12'h018
`define DPSC_PS_D0 2'h0
`define DPSC_PS_D1 2'h1
`define DPSC_PS_D2 2'h2
`define DPSC_PS_D3 2'h3
`define DPSC_BIT_WAKE_EN 8
`define DPSC_BIT_WAKE_ST 15
`define DPSC_BIT_FWD_D1 4
`define DPSC_NDEV 4
`define DPSC_IRQ_W 4
`define DPSC_IRQ_WAKE 0
`define DPSC_IRQ_D3 1
`define DPSC_IRQ_D0 2
`define DPSC_IRQ_PWRUP 3
`define DPSC_RESUME_CYC 16'h03e8
`endif

/* hdl/dpsc_pkg.sv */
// Types shared by the device power-state controller files.
// Assumes the constants header is on the include path.
`include "dpsc_defs.svh"
package dpsc_pkg;
   typedef logic [1:0] dpsc_pstate_t;
   // One APB request as seen by the slave.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } dpsc_apb_req_t;
   // One APB answer.
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dpsc_apb_rsp_t;
   typedef enum logic [2:0] {
      DPSC_R_IDLE = 3'b001,
      DPSC_R_ARMED = 3'b010,
      DPSC_R_SIGNAL = 3'b100
   } dpsc_rw_state_t;
endpackage

/* hdl/dpsc_sync.sv */
// Two-flop synchroniser for one level from outside the pclk domain.
// Assumes an asynchronous active-low reset; the output resets to zero.
`timescale 1ns/1ps
module dpsc_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_reg;
   // The first stage feeds only the second stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

/* hdl/dpsc_bus_floor.sv */
// Works out the deepest state the attached bus may take.
// Assumes per-device states and wake arming come from registers on pclk.
`timescale 1ns/1ps
`include "dpsc_defs.svh"
module dpsc_bus_floor
   import dpsc_pkg::*;
(
   input wire logic [4*2-1:0] dev_state,
   input wire logic [3:0] dev_wake_armed,
   input wire logic fwd_only_d1,
   output dpsc_pkg::dpsc_pstate_t floor_state
);
   dpsc_pstate_t min_st [0:`DPSC_NDEV];
   logic any_armed;
   assign min_st[0] = `DPSC_PS_D3;
   genvar i;
   generate
      for (i = 0; i < `DPSC_NDEV; i++) begin : g_min
         assign min_st[i+1] = (dev_state[2*i +: 2] < min_st[i]) ?
                              dev_state[2*i +: 2] : min_st[i];
      end
   endgenerate
   assign any_armed = |dev_wake_armed;
   always_comb begin
      floor_state = min_st[`DPSC_NDEV];
      if (any_armed && fwd_only_d1 && (floor_state > `DPSC_PS_D1)) begin
         floor_state = `DPSC_PS_D1;
      end
   end
endmodule

/* hdl/dpsc_top.sv */
// Device power-state controller: power register, wake reporting, bus power floor.
// Assumes an APB master on pclk and that the wake source and bus sideband pins are asynchronous.
`timescale 1ns/1ps
`include "dpsc_defs.svh"
// Summary of operation
// - Bus never deeper than shallowest device
// - Armed wake keeps bus in D1
// - Bus in D1 keeps devices' context
// - Power state read/written via control register
// - Wake raises wake pin and status bit
// - Wake reported only when enabled
// - Remote wake enable then resume signaling
// - Only D0 and D3 accepted
// - D3 holds no context, minimum power
// - D3 still accepts return to D0
// - Power return reset reinitialises fully
// - Both D0 and D3 supported
// - D0 functions restored without reboot
// - No default wake events generated
module dpsc_top
   import dpsc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wake_src_pin,
   input wire logic [7:0] dev_states_pin,
   input wire logic [3:0] dev_wake_pin,
   output logic wake_n_oe,
   output logic resume_out,
   output logic resume_oe_n,
   output logic func_en,
   output logic power_gate_n,
   output logic ctx_clear,
   output logic [1:0] bus_state,
   output logic irq
);
   import dpsc_pkg::*;

   dpsc_apb_req_t req;
   dpsc_pstate_t pstate_reg;
   logic wake_en_reg;
   logic wake_st_reg;
   logic fwd_d1_reg;
   logic bus_req_reg;
   dpsc_pstate_t bus_req_st_reg;
   logic usb_rw_en_reg;
   logic [`DPSC_IRQ_W-1:0] irq_stat_reg;
   logic [`DPSC_IRQ_W-1:0] irq_en_reg;
   logic [`DPSC_IRQ_W-1:0] irq_ev;
   logic [`DPSC_IRQ_W-1:0] irq_clr;
   logic wake_sync;
   logic wake_sync_d_reg;
   logic wake_rise;
   logic [7:0] dev_states_s;
   logic [3:0] dev_wake_s;
   dpsc_pstate_t floor_st;
   logic wr_stb;
   logic rd_stb;
   logic mapped;
   logic [31:0] rd_mux;
   logic go_d3;
   logic go_d0;
   logic first_cyc_reg;
   dpsc_rw_state_t rw_state_reg;
   logic [15:0] resume_cnt_reg;

   assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

   // The device-specific wake source and the bus sideband pins cross into pclk.
   dpsc_sync u_wake_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(wake_src_pin),
      .sync_out(wake_sync)
   );

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_st_sync
         dpsc_sync u_s (
            .pclk(pclk),
            .presetn(presetn),
            .async_in(dev_states_pin[g]),
            .sync_out(dev_states_s[g])
         );
      end
      for (g = 0; g < 4; g++) begin : g_wk_sync
         dpsc_sync u_w (
            .pclk(pclk),
            .presetn(presetn),
            .async_in(dev_wake_pin[g]),
            .sync_out(dev_wake_s[g])
         );
      end
   endgenerate

   dpsc_bus_floor u_floor (
      .dev_state(dev_states_s),
      .dev_wake_armed(dev_wake_s),
      .fwd_only_d1(fwd_d1_reg),
      .floor_state(floor_st)
   );

   // APB strobes; one wait state, and a write lands only on the edge that
   // sees pready high, so a held access phase cannot apply it twice.
   assign wr_stb = req.psel && req.penable && req.pwrite && pready;
   assign rd_stb = req.psel && req.penable && !req.pwrite;
   assign mapped = (req.paddr == `DPSC_OFF_PMCSR) || (req.paddr == `DPSC_OFF_BUSCTL) ||
                   (req.paddr == `DPSC_OFF_BUSST) || (req.paddr == `DPSC_OFF_IRQ_STAT) ||
                   (req.paddr == `DPSC_OFF_IRQ_EN) || (req.paddr == `DPSC_OFF_IRQ_CLR) ||
                   (req.paddr == `DPSC_OFF_USBCTL);

   always_comb begin
      go_d3 = 1'b0;
      go_d0 = 1'b0;
      if (wr_stb && (req.paddr == `DPSC_OFF_PMCSR)) begin
         go_d3 = (req.pwdata[1:0] == `DPSC_PS_D3) && (pstate_reg == `DPSC_PS_D0);
         go_d0 = (req.pwdata[1:0] == `DPSC_PS_D0) && (pstate_reg == `DPSC_PS_D3);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pstate_reg <= `DPSC_PS_D0;
      end else if (go_d3) begin
         pstate_reg <= `DPSC_PS_D3;
      end else if (go_d0) begin
         pstate_reg <= `DPSC_PS_D0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_en <= 1'b1;
         power_gate_n <= 1'b1;
         ctx_clear <= 1'b0;
      end else begin
         // Both follow the state being entered, so they switch on one edge.
         func_en <= (pstate_reg == `DPSC_PS_D0) ? !go_d3 : go_d0;
         power_gate_n <= (pstate_reg == `DPSC_PS_D0) ? !go_d3 : go_d0;
         ctx_clear <= go_d0;   // One-cycle pulse rebuilds context on re-entry.
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_cyc_reg <= 1'b1;
      end else begin
         first_cyc_reg <= 1'b0;
      end
   end

   // Wake source edge; only the second synchroniser stage is looked at.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_sync_d_reg <= 1'b0;
      end else begin
         wake_sync_d_reg <= wake_sync;
      end
   end
   assign wake_rise = wake_sync && !wake_sync_d_reg;

   // Gated by enable
   // Set wins over a write-one clear in the same cycle so no wake is lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_en_reg <= 1'b0;
         wake_st_reg <= 1'b0;
      end else begin
         if (wr_stb && (req.paddr == `DPSC_OFF_PMCSR)) begin
            wake_en_reg <= req.pwdata[`DPSC_BIT_WAKE_EN];
         end
         if (wake_rise && wake_en_reg) begin
            wake_st_reg <= 1'b1;
         end else if (wr_stb && (req.paddr == `DPSC_OFF_PMCSR) &&
                      req.pwdata[`DPSC_BIT_WAKE_ST]) begin
            wake_st_reg <= 1'b0;
         end
      end
   end

   // Drive wake pin
   // Open-drain wake line: enable low means pulling the line low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_n_oe <= 1'b1;
      end else begin
         wake_n_oe <= !(wake_st_reg && wake_en_reg);
      end
   end

   // Bus control: forwarding mode and software's requested bus state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_d1_reg <= 1'b0;
         bus_req_st_reg <= `DPSC_PS_D0;
         usb_rw_en_reg <= 1'b0;
      end else if (wr_stb && (req.paddr == `DPSC_OFF_BUSCTL)) begin
         bus_req_st_reg <= req.pwdata[1:0];
         fwd_d1_reg <= req.pwdata[`DPSC_BIT_FWD_D1];
      end else if (wr_stb && (req.paddr == `DPSC_OFF_USBCTL)) begin
         usb_rw_en_reg <= req.pwdata[0];
      end
   end

   // D1 keeps context
   // Taking the shallower of request and floor means the bus never drops power
   // beneath a device; in D1 the power gate stays on so no context is lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state <= `DPSC_PS_D0;
      end else begin
         bus_state <= (bus_req_st_reg < floor_st) ? bus_req_st_reg : floor_st;
      end
   end

   // Remote wake resume
   // Resume signaling is sent only once the host enabled remote wake.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rw_state_reg <= DPSC_R_IDLE;
         resume_cnt_reg <= 16'h0000;
      end else begin
         unique case (rw_state_reg)
            DPSC_R_IDLE: begin
               if (usb_rw_en_reg) begin
                  rw_state_reg <= DPSC_R_ARMED;
               end
            end
            DPSC_R_ARMED: begin
               if (!usb_rw_en_reg) begin
                  rw_state_reg <= DPSC_R_IDLE;
               end else if (wake_rise) begin
                  rw_state_reg <= DPSC_R_SIGNAL;
                  resume_cnt_reg <= `DPSC_RESUME_CYC;
               end
            end
            DPSC_R_SIGNAL: begin
               if (resume_cnt_reg == 16'h0001) begin
                  rw_state_reg <= DPSC_R_IDLE;
               end
               resume_cnt_reg <= resume_cnt_reg - 16'h0001;
            end
            default: begin
               rw_state_reg <= DPSC_R_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume_out <= 1'b0;
         resume_oe_n <= 1'b1;
      end else begin
         resume_out <= (rw_state_reg == DPSC_R_SIGNAL);
         resume_oe_n <= (rw_state_reg != DPSC_R_SIGNAL);
      end
   end

   // Interrupt events: wake, D3 entry, D0 re-entry, power-on reset done.
   assign irq_ev[`DPSC_IRQ_WAKE] = wake_rise && wake_en_reg;
   assign irq_ev[`DPSC_IRQ_D3] = go_d3;
   assign irq_ev[`DPSC_IRQ_D0] = go_d0;
   assign irq_ev[`DPSC_IRQ_PWRUP] = first_cyc_reg;
   assign irq_clr = (wr_stb && (req.paddr == `DPSC_OFF_IRQ_CLR)) ?
                    req.pwdata[`DPSC_IRQ_W-1:0] : '0;

   // Sticky status; a set in the clearing cycle survives.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_reg <= '0;
      end else if (wr_stb && (req.paddr == `DPSC_OFF_IRQ_EN)) begin
         irq_en_reg <= req.pwdata[`DPSC_IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_reg | irq_ev) & irq_en_reg);
      end
   end

   // Read multiplexer; write-only and unmapped words read as zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (req.paddr)
         `DPSC_OFF_PMCSR: begin
            rd_mux[1:0] = pstate_reg;
            rd_mux[`DPSC_BIT_WAKE_EN] = wake_en_reg;
            rd_mux[`DPSC_BIT_WAKE_ST] = wake_st_reg;
         end
         `DPSC_OFF_BUSCTL: begin
            rd_mux[1:0] = bus_req_st_reg;
            rd_mux[`DPSC_BIT_FWD_D1] = fwd_d1_reg;
         end
         `DPSC_OFF_BUSST: begin
            rd_mux[1:0] = bus_state;
            rd_mux[5:4] = floor_st;
         end
         `DPSC_OFF_IRQ_STAT: rd_mux[`DPSC_IRQ_W-1:0] = irq_stat_reg;
         `DPSC_OFF_IRQ_EN: rd_mux[`DPSC_IRQ_W-1:0] = irq_en_reg;
         `DPSC_OFF_USBCTL: rd_mux[0] = usb_rw_en_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Registered answer: pready rises one cycle into the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= req.psel && req.penable && !pready;
         pslverr <= req.psel && req.penable && !pready && !mapped;
         prdata <= (rd_stb && !pready) ? rd_mux : 32'h0000_0000;
      end
   end
endmodule

/* testbench/dpsc_checker.sv */
// Port checker for dpsc_top: APB answer timing, bus floor, state pins, wake and resume.
// Assumes it is bound to dpsc_top and sees only that module's ports.
`timescale 1ns/1ps
module dpsc_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wake_src_pin,
   input wire logic [7:0] dev_states_pin,
   input wire logic wake_n_oe,
   input wire logic resume_oe_n,
   input wire logic func_en,
   input wire logic power_gate_n,
   input wire logic ctx_clear,
   input wire logic [1:0] bus_state
);
   logic [1:0] dmin;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Shallowest state among the attached devices.
   always_comb begin
      dmin = 2'h3;
      for (int i = 0; i < 4; i++) begin
         if (dev_states_pin[2*i +: 2] < dmin) begin
            dmin = dev_states_pin[2*i +: 2];
         end
      end
   end
   a_ready_next: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after access edge");
   a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
      else $error("pready outside access or too long");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // Sync latency is a few cycles, so the floor is judged once inputs settle.
   a_bus_floor: assert property ($stable(dev_states_pin)[*6] |-> bus_state <= dmin)
      else $error("bus deeper than shallowest device");
   a_two_states: assert property (func_en == power_gate_n)
      else $error("function and power gate disagree");
   a_ctx_pulse: assert property (ctx_clear |-> ##[0:2] func_en ##1 !ctx_clear)
      else $error("context clear not a pulse on return");
   a_wake_cause: assert property ($fell(wake_n_oe) |-> $past(wake_src_pin, 2))
      else $error("wake line pulled without a wake source");
   a_resume_hold: assert property ($fell(resume_oe_n) |=> !resume_oe_n [*8])
      else $error("resume signaling too short");
   a_reset_state: assert property ($past(presetn) == 1'b0 |-> func_en && wake_n_oe
         && resume_oe_n && bus_state == 2'h0)
      else $error("outputs not at reset values");
   c_slverr: cover property (pready && pslverr);
   c_wake: cover property ($fell(wake_n_oe));
   c_ctx: cover property (ctx_clear);
   c_resume: cover property ($fell(resume_oe_n));
endmodule

bind dpsc_top dpsc_checker dpsc_checker_i (.pclk, .presetn, .psel, .penable, .pready,
   .pslverr, .wake_src_pin, .dev_states_pin, .wake_n_oe, .resume_oe_n, .func_en,
   .power_gate_n, .ctx_clear, .bus_state);

/* testbench/dpsc_host_model.sv */
// Host bus controller model: an APB master that software policy drives by task calls.
// Assumes a single pclk domain; signals change only by NBA just after a rising edge.
`timescale 1ns/1ps
module dpsc_host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // Host commands states and remote wake only through this transfer.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Hold everything until pready is seen; the watchdog ends a hang.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for dpsc_top with a host model on the APB side.
// Assumes the checker binds itself to dpsc_top.
`timescale 1ns/1ps
`include "dpsc_defs.svh"
module tb;
   import dpsc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_src_pin;
   logic wake_n_oe, resume_out, resume_oe_n, func_en, power_gate_n, ctx_clear, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [7:0] dev_states_pin;
   logic [3:0] dev_wake_pin;
   logic [1:0] bus_state;
   logic e;
   int n_errors = 0;
   int num_checks = 0;
   dpsc_top dpsc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .wake_src_pin, .dev_states_pin, .dev_wake_pin, .wake_n_oe,
      .resume_out, .resume_oe_n, .func_en, .power_gate_n, .ctx_clear, .bus_state, .irq);
   dpsc_host_model dpsc_host_model_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      dpsc_host_model_i.xfer(1'b1, a, d, r, e);
      repeat (4) @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a);
      dpsc_host_model_i.xfer(1'b0, a, 32'h0, r, e);
   endtask
   // A wake source pulse long enough to pass the synchroniser.
   task automatic pulse_wake();
      wake_src_pin <= 1'b1;
      repeat (10) @(posedge pclk);
      wake_src_pin <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic t_reset();
      rd(`DPSC_OFF_PMCSR);
      chk(r & 32'h8103, 32'h0);
      rd(`DPSC_OFF_IRQ_STAT);
      chk(r & 32'h8, 32'h8);
      chk({30'h0, func_en, power_gate_n}, 32'h3);
      wr(`DPSC_OFF_IRQ_EN, 32'h8);
      chk({31'h0, irq}, 32'h1);
      wr(`DPSC_OFF_IRQ_CLR, 32'h8);
      chk({31'h0, irq}, 32'h0);
      rd(12'h01c);
      chk({e, r[30:0]}, 32'h80000000);
   endtask
   task automatic t_states();
      for (int s = 1; s < 3; s++) begin
         wr(`DPSC_OFF_PMCSR, 32'(s));
         rd(`DPSC_OFF_PMCSR);
         chk(r & 32'h3, 32'h0);
      end
      wr(`DPSC_OFF_PMCSR, 32'h3);
      rd(`DPSC_OFF_PMCSR);
      chk(r & 32'h3, 32'h3);
      chk({29'h0, func_en, power_gate_n, irq}, 32'h0);
      wr(`DPSC_OFF_PMCSR, 32'h0);
      chk({30'h0, func_en, power_gate_n}, 32'h3);
      rd(`DPSC_OFF_IRQ_STAT);
      chk(r & 32'h6, 32'h6);
   endtask
   task automatic t_wake();
      pulse_wake();
      chk({31'h0, wake_n_oe}, 32'h1);
      rd(`DPSC_OFF_PMCSR);
      chk(r & 32'h8000, 32'h0);
      wr(`DPSC_OFF_USBCTL, 32'h1);
      wr(`DPSC_OFF_PMCSR, 32'h100);
      pulse_wake();
      chk({29'h0, resume_out, wake_n_oe, resume_oe_n}, 32'h4);
      rd(`DPSC_OFF_PMCSR);
      chk(r & 32'h8100, 32'h8100);
      wr(`DPSC_OFF_PMCSR, 32'h8100);
      chk({31'h0, wake_n_oe}, 32'h1);
      repeat (1000) @(posedge pclk);
      chk({30'h0, resume_out, resume_oe_n}, 32'h1);
   endtask
   task automatic t_bus();
      dev_states_pin <= 8'hff;
      wr(`DPSC_OFF_BUSCTL, 32'h3);
      repeat (6) @(posedge pclk);
      chk({30'h0, bus_state}, 32'h3);
      dev_states_pin <= 8'hf7;
      repeat (8) @(posedge pclk);
      chk({30'h0, bus_state}, 32'h1);
      dev_states_pin <= 8'hbf;
      dev_wake_pin <= 4'h8;
      wr(`DPSC_OFF_BUSCTL, 32'h13);
      repeat (6) @(posedge pclk);
      rd(`DPSC_OFF_BUSST);
      chk(r & 32'h3, 32'h1);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog well beyond the roughly 1200 cycles the scenarios need.
   initial begin
      #200us;
      n_errors++;
      wrap_up();
   end
   initial begin
      presetn = 1'b0;
      wake_src_pin = 1'b0;
      dev_states_pin = 8'h00;
      dev_wake_pin = 4'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_states();
      t_wake();
      t_bus();
      wrap_up();
   end
endmodule
